// ### rtl/fps_pkg.sv
// fps_pkg: constants, field positions and carrier types of the flash
// program/erase/security sequencer.
// assumes: 18-bit physical flash addresses, scratchpad above main memory.
package fps_pkg;

  ////////////////////////////////////////////////////////////////////////
  // address map
  localparam logic [17:0] SCR_BASE = 18'h2_0000;
  localparam logic [17:0] SCR_LAST = 18'h2_00ff;
  localparam logic [17:0] PAGE_MASK = 18'h3_fc00;
  localparam logic [17:0] SCR_PAGE_MASK = 18'h3_ff80;
  localparam logic [17:0] BLK4_MASK = 18'h3_fffc;
  localparam logic [17:0] BLK2_MASK = 18'h3_fffe;
  localparam logic [17:0] ALL_ONES = 18'h3_ffff;
  localparam logic [16:0] WEL_LARGE = 17'h1_fbfe;
  localparam logic [16:0] RDL_LARGE = 17'h1_fbff;
  localparam logic [16:0] WEL_SMALL = 17'h0_fffe;
  localparam logic [16:0] RDL_SMALL = 17'h0_ffff;
  localparam logic [16:0] RSV_BASE = 17'h1_fc00;
  localparam int unsigned LBLK_LSB = 14;
  localparam int unsigned LBLK_MSB = 16;
  localparam int unsigned FAL_LOW_BITS = 9;
  localparam logic [8:0] FAL_LOW = 9'h000;
  localparam logic [7:0] ERASED = 8'hff;
  localparam logic [31:0] ERASED_WORD = 32'hffff_ffff;
  localparam logic [7:0] SCR_HI_PAGE = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // control register fields and array command byte counts
  localparam int unsigned PSC_REDIRECT = 0;
  localparam int unsigned PSC_ERASE = 1;
  localparam int unsigned PSC_SCRATCH = 2;
  localparam int unsigned FSC_WE = 0;
  localparam int unsigned CCH_BLKW = 0;
  localparam int unsigned BANK_LSB = 4;
  localparam int unsigned BANK_MSB = 5;
  localparam logic [2:0] NB_ONE = 3'h1;
  localparam logic [2:0] NB_SCR = 3'h2;
  localparam logic [2:0] NB_CODE = 3'h4;

  ////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_WAIT = 2'h2
  } fps_state_t;

  typedef enum logic [1:0] {
    ARR_READ = 2'h0,
    ARR_PROG = 2'h1,
    ARR_ERASE_PAGE = 2'h2,
    ARR_ERASE_ALL = 2'h3
  } fps_arr_op_t;

  typedef enum logic [1:0] {
    JT_READ = 2'h0,
    JT_WRITE = 2'h1,
    JT_ERASE = 2'h2
  } fps_jtag_op_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] data;
  } fps_cpu_req_t;

  typedef struct packed {
    logic valid;
    fps_jtag_op_t op;
    logic [17:0] addr;
    logic [7:0] data;
  } fps_jtag_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [7:0] data;
  } fps_xram_t;

  typedef struct packed {
    logic valid;
    fps_arr_op_t op;
    logic [17:0] addr;
    logic [31:0] data;
    logic [2:0] nbytes;
  } fps_arr_cmd_t;

endpackage

// ### rtl/fps_blk_buf.sv
// fps_blk_buf: four-byte gather buffer for block programming.
// assumes: store and clear come from the sequencer on the same clock.
`timescale 1ns/1ps
`default_nettype none
module fps_blk_buf (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic store,
  input wire logic clear,
  input wire logic [1:0] idx,
  input wire logic [7:0] data,
  output logic [31:0] word
);

  logic [31:0] next_word;

  // bytes never written stay erased, so a partial block leaves flash intact
  always_comb begin
    next_word = word;
    if (clear) begin
      next_word = fps_pkg::ERASED_WORD;
    end else if (store) begin
      next_word[idx*8 +: 8] = data;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      word <= fps_pkg::ERASED_WORD;
    end else begin
      word <= next_word;
    end
  end

endmodule
`default_nettype wire

// ### rtl/fps_sequencer.sv
// fps_sequencer: flash program/erase sequencing and protection checks
// between cpu, jtag and the flash array.
// assumes: array acks every command after at least one cycle and times
// program/erase itself; all requesters run on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module fps_sequencer #(
  parameter bit LARGE_MEM = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] program_store_control,
  input wire logic [7:0] flash_scale_control,
  input wire logic [7:0] cache_control,
  input wire logic [7:0] program_bank_select,
  input wire logic acl_wr,
  input wire logic [7:0] acl_wdata,
  input wire fps_pkg::fps_cpu_req_t cpu_req,
  input wire logic [16:0] cpu_pc,
  input wire fps_pkg::fps_jtag_req_t jtag_req,
  input wire logic arr_ack,
  input wire logic [7:0] arr_rdata,
  input wire logic [7:0] arr_wel,
  input wire logic [7:0] arr_rdl,
  output fps_pkg::fps_xram_t xram_wr,
  output fps_pkg::fps_arr_cmd_t arr_cmd,
  output logic cpu_rvalid,
  output logic [7:0] cpu_rdata,
  output logic cpu_refused,
  output logic jtag_done,
  output logic jtag_refused,
  output logic [7:0] jtag_rdata,
  output logic dbg_blocked,
  output logic flash_busy_flag,
  output logic [7:0] flash_access_limit
);

  ////////////////////////////////////////////////////////////////////////
  // decode

  logic redirect, erase_en, scr_en, sw_en, blkw;
  logic [1:0] upper_bank_select;
  logic [16:0] wel_a, rdl_a, access_limit_address;
  logic [17:0] cpu_pa, ja;
  logic cpu_scr, hi_code, fw_ok, rd_ok, lock_pg, blk_last;
  logic jscr, jlock_loc, jrd_ok, jwe_ok;
  logic [2:0] jblk;
  logic [1:0] bidx;
  logic [31:0] buf_word;
  logic buf_store, buf_clear;

  function automatic logic f_rsv(input logic [17:0] a);
    return LARGE_MEM && !a[17] && (a[16:0] >= fps_pkg::RSV_BASE);
  endfunction

  function automatic logic [17:0] f_page(input logic [17:0] a);
    return a[17] ? (a & fps_pkg::SCR_PAGE_MASK) : (a & fps_pkg::PAGE_MASK);
  endfunction

  always_comb begin
    redirect = program_store_control[fps_pkg::PSC_REDIRECT];
    erase_en = program_store_control[fps_pkg::PSC_ERASE];
    scr_en = program_store_control[fps_pkg::PSC_SCRATCH];
    sw_en = flash_scale_control[fps_pkg::FSC_WE];
    blkw = cache_control[fps_pkg::CCH_BLKW];
    upper_bank_select = program_bank_select[fps_pkg::BANK_MSB:fps_pkg::BANK_LSB];
    wel_a = LARGE_MEM ? fps_pkg::WEL_LARGE : fps_pkg::WEL_SMALL;
    rdl_a = LARGE_MEM ? fps_pkg::RDL_LARGE : fps_pkg::RDL_SMALL;
    access_limit_address = {flash_access_limit, fps_pkg::FAL_LOW};
    cpu_scr = scr_en && (cpu_req.addr[15:8] == fps_pkg::SCR_HI_PAGE);
    if (cpu_scr) begin
      cpu_pa = {fps_pkg::SCR_BASE[17:8], cpu_req.addr[7:0]};
    end else if (cpu_req.addr[15]) begin
      cpu_pa = {1'b0, upper_bank_select, cpu_req.addr[14:0]};
    end else begin
      cpu_pa = {3'b000, cpu_req.addr[14:0]};
    end
    hi_code = cpu_pc >= access_limit_address;
    // scratchpad sits above every limit, so it is never in the lower part
    rd_ok = !(hi_code && !cpu_pa[17] && (cpu_pa[16:0] < access_limit_address)) && !f_rsv(cpu_pa);
    fw_ok = sw_en && rd_ok;
    lock_pg = f_page(cpu_pa) == f_page({1'b0, wel_a});
    blk_last = &(cpu_pa | (cpu_scr ? fps_pkg::BLK2_MASK : fps_pkg::BLK4_MASK));
    bidx = cpu_scr ? {1'b0, cpu_pa[0]} : cpu_pa[1:0];
    ja = jtag_req.addr;
    jscr = ja[17];
    jblk = ja[fps_pkg::LBLK_MSB:fps_pkg::LBLK_LSB];
    jlock_loc = !jscr && ((ja[16:0] == wel_a) || (ja[16:0] == rdl_a));
    jrd_ok = !f_rsv(ja) && (jlock_loc || (jscr ? |arr_rdl : arr_rdl[jblk]));
    jwe_ok = !f_rsv(ja) && (jscr ? |arr_wel : arr_wel[jblk]);
  end

  fps_blk_buf u_blk_buf (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .store(buf_store),
    .clear(buf_clear),
    .idx(bidx),
    .data(cpu_req.data),
    .word(buf_word)
  );

  ////////////////////////////////////////////////////////////////////////
  // sequencer

  fps_pkg::fps_state_t state, next_state;
  fps_pkg::fps_arr_cmd_t next_cmd;
  fps_pkg::fps_xram_t next_xram;
  logic src_jtag, next_src_jtag, op_rd, next_op_rd;
  logic next_busy, next_rvalid, next_cref, next_jdone, next_jref;
  logic [7:0] next_rdata, next_jrdata;
  logic iss, iss_j;
  fps_pkg::fps_arr_op_t iss_op;
  logic [17:0] iss_addr;
  logic [31:0] iss_data;
  logic [2:0] iss_n;

  always_comb begin
    next_state = state;
    next_src_jtag = src_jtag;
    next_op_rd = op_rd;
    next_cmd = '0;
    next_busy = flash_busy_flag;
    next_rvalid = 1'b0;
    next_rdata = cpu_rdata;
    next_cref = 1'b0;
    next_jdone = 1'b0;
    next_jref = 1'b0;
    next_jrdata = jtag_rdata;
    buf_store = 1'b0;
    buf_clear = 1'b0;
    iss = 1'b0;
    iss_j = 1'b0;
    iss_op = fps_pkg::ARR_READ;
    iss_addr = cpu_pa;
    iss_data = {24'h00_0000, cpu_req.data};
    iss_n = fps_pkg::NB_ONE;
    next_xram = '0;
    if (cpu_req.wr && !redirect) begin
      next_xram = '{valid: 1'b1, addr: cpu_req.addr, data: cpu_req.data};
    end
    case (state)
      fps_pkg::ST_IDLE: begin
        if (cpu_req.wr && redirect) begin
          if (fw_ok) begin
            if (erase_en) begin
              if (!lock_pg) begin
                iss = 1'b1;
                iss_op = fps_pkg::ARR_ERASE_PAGE;
                iss_addr = f_page(cpu_pa);
              end
            end else if (blkw) begin
              buf_store = 1'b1;
              if (blk_last) begin
                iss = 1'b1;
                buf_clear = 1'b1;
                iss_op = fps_pkg::ARR_PROG;
                iss_data = buf_word;
                iss_data[bidx*8 +: 8] = cpu_req.data;
                iss_addr = cpu_pa & (cpu_scr ? fps_pkg::BLK2_MASK : fps_pkg::BLK4_MASK);
                iss_n = cpu_scr ? fps_pkg::NB_SCR : fps_pkg::NB_CODE;
              end
            end else begin
              iss = 1'b1;
              iss_op = fps_pkg::ARR_PROG;
            end
          end
        end else if (cpu_req.rd) begin
          if (rd_ok) begin
            iss = 1'b1;
          end else begin
            next_rvalid = 1'b1;
            next_rdata = fps_pkg::ERASED;
            next_cref = 1'b1;
          end
        end else if (jtag_req.valid) begin
          iss_j = 1'b1;
          iss_addr = ja;
          iss_data = {24'h00_0000, jtag_req.data};
          case (jtag_req.op)
            fps_pkg::JT_READ: begin
              iss = jrd_ok;
            end
            fps_pkg::JT_WRITE: begin
              iss = jlock_loc || jwe_ok;
              iss_op = fps_pkg::ARR_PROG;
            end
            fps_pkg::JT_ERASE: begin
              iss = jlock_loc || jwe_ok;
              iss_op = jlock_loc ? fps_pkg::ARR_ERASE_ALL : fps_pkg::ARR_ERASE_PAGE;
              iss_addr = jlock_loc ? 18'h0_0000 : f_page(ja);
            end
            default: begin
              iss = 1'b0;
            end
          endcase
          if (!iss) begin
            next_jdone = 1'b1;
            next_jref = 1'b1;
            next_jrdata = fps_pkg::ERASED;
          end
        end
        // jtag losing to the cpu is refused, else the debugger would wait forever
        if (jtag_req.valid && !iss_j) begin
          next_jdone = 1'b1;
          next_jref = 1'b1;
        end
      end
      fps_pkg::ST_WAIT: begin
        // new cpu reads cannot be queued behind a running operation
        next_cref = cpu_req.rd;
        next_rvalid = cpu_req.rd;
        next_jdone = jtag_req.valid;
        next_jref = jtag_req.valid;
        if (arr_ack) begin
          next_state = fps_pkg::ST_IDLE;
          next_busy = 1'b0;
          if (src_jtag) begin
            next_jdone = 1'b1;
            next_jref = jtag_req.valid;
            next_jrdata = op_rd ? arr_rdata : jtag_rdata;
          end else if (op_rd) begin
            next_rvalid = 1'b1;
            next_rdata = arr_rdata;
          end
        end
      end
      default: begin
        next_state = fps_pkg::ST_IDLE;
        next_busy = 1'b0;
      end
    endcase
    if (iss) begin
      // one array command per block: block and byte cost the same time
      next_cmd = '{valid: 1'b1, op: iss_op, addr: iss_addr, data: iss_data, nbytes: iss_n};
      next_state = fps_pkg::ST_WAIT;
      next_src_jtag = iss_j;
      next_op_rd = iss_op == fps_pkg::ARR_READ;
      next_busy = iss_op != fps_pkg::ARR_READ;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state <= fps_pkg::ST_IDLE;
      src_jtag <= 1'b0;
      op_rd <= 1'b0;
      arr_cmd <= '0;
      xram_wr <= '0;
      flash_busy_flag <= 1'b0;
      cpu_rvalid <= 1'b0;
      cpu_rdata <= 8'h00;
      cpu_refused <= 1'b0;
      jtag_done <= 1'b0;
      jtag_refused <= 1'b0;
      jtag_rdata <= 8'h00;
    end else begin
      state <= next_state;
      src_jtag <= next_src_jtag;
      op_rd <= next_op_rd;
      arr_cmd <= next_cmd;
      xram_wr <= next_xram;
      flash_busy_flag <= next_busy;
      cpu_rvalid <= next_rvalid;
      cpu_rdata <= next_rdata;
      cpu_refused <= next_cref;
      jtag_done <= next_jdone;
      jtag_refused <= next_jref;
      jtag_rdata <= next_jrdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // access limit and debug lock

  logic acl_written, next_acl_written, next_dbg;
  logic [7:0] next_acl;

  always_comb begin
    next_acl = flash_access_limit;
    next_acl_written = acl_written;
    if (acl_wr && !acl_written) begin
      next_acl = acl_wdata;
      next_acl_written = 1'b1;
    end
    next_dbg = !arr_rdl[cpu_pc[fps_pkg::LBLK_MSB:fps_pkg::LBLK_LSB]];
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      flash_access_limit <= 8'h00;
      acl_written <= 1'b0;
      dbg_blocked <= 1'b0;
    end else begin
      flash_access_limit <= next_acl;
      acl_written <= next_acl_written;
      dbg_blocked <= next_dbg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  logic idle_wr;
  assign idle_wr = (state == fps_pkg::ST_IDLE) && cpu_req.wr && redirect && fw_ok;

  property p_page_erase;
    @(posedge sys_clk) disable iff (!rstn)
    arr_cmd.valid && arr_cmd.op == fps_pkg::ARR_ERASE_PAGE |->
      (arr_cmd.addr[17] ? (arr_cmd.addr[6:0] == 7'h00 && arr_cmd.addr <= fps_pkg::SCR_LAST)
                        : arr_cmd.addr[9:0] == 10'h000);
  endproperty
  a_page_erase: assert property (p_page_erase) else $error("erase not page aligned");

  property p_erase_start;
    @(posedge sys_clk) disable iff (!rstn)
    idle_wr && erase_en && !lock_pg |=> arr_cmd.valid && arr_cmd.op == fps_pkg::ARR_ERASE_PAGE ##1 flash_busy_flag;
  endproperty
  a_erase_start: assert property (p_erase_start) else $error("erase not started");

  property p_byte_prog;
    @(posedge sys_clk) disable iff (!rstn)
    idle_wr && !erase_en && !blkw |=> arr_cmd.valid && arr_cmd.nbytes == fps_pkg::NB_ONE
      && arr_cmd.data[7:0] == $past(cpu_req.data);
  endproperty
  a_byte_prog: assert property (p_byte_prog) else $error("byte program missing");

  property p_block_hold;
    @(posedge sys_clk) disable iff (!rstn)
    idle_wr && !erase_en && blkw && !blk_last |=> !arr_cmd.valid;
  endproperty
  a_block_hold: assert property (p_block_hold) else $error("block programmed early");

  property p_xram;
    @(posedge sys_clk) disable iff (!rstn)
    cpu_req.wr |=> (xram_wr.valid == !$past(redirect));
  endproperty
  a_xram: assert property (p_xram) else $error("write misrouted");

  property p_busy;
    @(posedge sys_clk) disable iff (!rstn)
    flash_busy_flag && !arr_ack |=> flash_busy_flag;
  endproperty
  a_busy: assert property (p_busy) else $error("busy dropped early");

  property p_acl_once;
    @(posedge sys_clk) disable iff (!rstn)
    acl_written && acl_wr |=> $stable(flash_access_limit);
  endproperty
  a_acl_once: assert property (p_acl_once) else $error("limit rewritten");

  property p_fw_no_lock_erase;
    @(posedge sys_clk) disable iff (!rstn)
    arr_cmd.valid && !src_jtag |-> arr_cmd.op != fps_pkg::ARR_ERASE_ALL
      && !(arr_cmd.op == fps_pkg::ARR_ERASE_PAGE && arr_cmd.addr == f_page({1'b0, wel_a}));
  endproperty
  a_fw_no_lock_erase: assert property (p_fw_no_lock_erase) else $error("firmware erased lock page");

  property p_jtag_full;
    @(posedge sys_clk) disable iff (!rstn)
    state == fps_pkg::ST_IDLE && !cpu_req.wr && !cpu_req.rd && jtag_req.valid
      && jtag_req.op == fps_pkg::JT_ERASE && jlock_loc |=> arr_cmd.op == fps_pkg::ARR_ERASE_ALL;
  endproperty
  a_jtag_full: assert property (p_jtag_full) else $error("full erase missing");

  c_block: cover property (@(posedge sys_clk) disable iff (!rstn)
    arr_cmd.valid && arr_cmd.nbytes == fps_pkg::NB_CODE);
  c_jtag_ref: cover property (@(posedge sys_clk) disable iff (!rstn) jtag_refused);
  c_erase_done: cover property (@(posedge sys_clk) disable iff (!rstn) flash_busy_flag ##1 !flash_busy_flag);

endmodule
`default_nettype wire

// ### rtl/fps_sequencer_unused_placeholder_none.sv
// fps_sequencer_unused_placeholder_none: intentionally empty compile unit.
// assumes: nothing.

// ### tb/fps_flash_model.sv
// fps_flash_model: behavioural flash array behind the sequencer.
// assumes: large part, one command at a time, ack_delay of 1 or more.
`timescale 1ns/1ps
`default_nettype none
module fps_flash_model (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [3:0] ack_delay,
  input wire fps_pkg::fps_arr_cmd_t arr_cmd,
  output logic arr_ack,
  output logic [7:0] arr_rdata,
  output logic [7:0] arr_wel,
  output logic [7:0] arr_rdl
);
  logic [7:0] mem [int];
  fps_pkg::fps_arr_cmd_t cmd;
  int cnt;
  int pg;
  function automatic logic [7:0] rd(input int a);
    return mem.exists(a) ? mem[a] : fps_pkg::ERASED;
  endfunction
  ////////////////////////////////////////
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      arr_ack <= 1'b0;
      arr_rdata <= 8'h00;
      arr_wel <= 8'hff;
      arr_rdl <= 8'hff;
      cnt = 0;
    end else begin
      arr_ack <= 1'b0;
      // idle read bus keeps toggling so a stale byte never looks valid
      arr_rdata <= ~arr_rdata;
      if (arr_cmd.valid) begin
        cmd = arr_cmd;
        cnt = ack_delay;
      end else if (cnt > 0) begin
        cnt--;
        if (cnt == 0) begin
          arr_ack <= 1'b1;
          pg = (cmd.addr >= fps_pkg::SCR_BASE) ? 128 : 1024;
          case (cmd.op)
            fps_pkg::ARR_READ: arr_rdata <= rd(cmd.addr);
            fps_pkg::ARR_PROG: begin
              // programming only clears bits
              for (int i = 0; i < cmd.nbytes; i++) mem[cmd.addr + i] = rd(cmd.addr + i) & cmd.data[8*i +: 8];
            end
            fps_pkg::ARR_ERASE_PAGE: begin
              for (int i = 0; i < pg; i++) mem.delete((cmd.addr & ~(pg - 1)) + i);
            end
            default: mem.delete();
          endcase
        end
      end
      arr_wel <= rd(fps_pkg::WEL_LARGE);
      arr_rdl <= rd(fps_pkg::RDL_LARGE);
    end
  end
endmodule
`default_nettype wire

// ### tb/fps_sequencer_tb_top.sv
// fps_sequencer_tb_top: directed bench for the flash sequencer.
// assumes: large part, behavioural array model on the far side.
`timescale 1ns/1ps
`default_nettype none
module fps_sequencer_tb_top;
  logic sys_clk, rstn, acl_wr, arr_ack, dbg_blocked, flash_busy_flag, rf;
  logic cpu_rvalid, cpu_refused, jtag_done, jtag_refused;
  logic [7:0] psc, fsc, cch, bank, acl_wdata, arr_rdata, arr_wel, arr_rdl, d;
  logic [7:0] cpu_rdata, jtag_rdata, flash_access_limit;
  logic [16:0] cpu_pc;
  logic [3:0] lat;
  logic [31:0] w;
  fps_pkg::fps_cpu_req_t cpu_req;
  fps_pkg::fps_jtag_req_t jtag_req;
  fps_pkg::fps_xram_t xram_wr, x;
  fps_pkg::fps_arr_cmd_t arr_cmd, c;
  int bc, bc1, errors, samples_checked;
  fps_sequencer #(.LARGE_MEM(1'b1)) i_dut (.sys_clk(sys_clk), .rstn(rstn), .program_store_control(psc),
    .flash_scale_control(fsc), .cache_control(cch), .program_bank_select(bank), .acl_wr(acl_wr),
    .acl_wdata(acl_wdata), .cpu_req(cpu_req), .cpu_pc(cpu_pc), .jtag_req(jtag_req), .arr_ack(arr_ack),
    .arr_rdata(arr_rdata), .arr_wel(arr_wel), .arr_rdl(arr_rdl), .xram_wr(xram_wr), .arr_cmd(arr_cmd),
    .cpu_rvalid(cpu_rvalid), .cpu_rdata(cpu_rdata), .cpu_refused(cpu_refused), .jtag_done(jtag_done),
    .jtag_refused(jtag_refused), .jtag_rdata(jtag_rdata), .dbg_blocked(dbg_blocked),
    .flash_busy_flag(flash_busy_flag), .flash_access_limit(flash_access_limit));
  fps_flash_model i_arr (.sys_clk(sys_clk), .rstn(rstn), .ack_delay(lat), .arr_cmd(arr_cmd),
    .arr_ack(arr_ack), .arr_rdata(arr_rdata), .arr_wel(arr_wel), .arr_rdl(arr_rdl));
  ////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_cmd(input fps_pkg::fps_arr_op_t op, input logic [17:0] a);
    chk({c.valid, c.op, c.addr}, {1'b1, op, a});
  endtask
  task automatic on(input logic [7:0] p, input logic [7:0] k);
    cch <= k;
    fsc <= 8'h01;
    @(posedge sys_clk);
    psc <= p & 8'hfe;
    @(posedge sys_clk);
    psc <= p;
    @(posedge sys_clk);
  endtask
  task automatic off();
    psc <= psc & 8'hfd;
    @(posedge sys_clk);
    psc <= 8'h00;
    @(posedge sys_clk);
    fsc <= 8'h00;
    @(posedge sys_clk);
  endtask
  // firmware waits for busy low before the next write
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    cpu_req <= '{1'b1, 1'b0, a, v};
    @(posedge sys_clk);
    cpu_req.wr <= 1'b0;
    #1;
    c = arr_cmd;
    x = xram_wr;
    for (bc = 0; bc < 60 && flash_busy_flag === 1'b1; bc++) begin
      @(posedge sys_clk);
      #1;
    end
    chk(flash_busy_flag, 1'b0);
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [15:0] a);
    cpu_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk);
    cpu_req.rd <= 1'b0;
    #1;
    for (bc = 0; bc < 60 && cpu_rvalid !== 1'b1; bc++) begin
      @(posedge sys_clk);
      #1;
    end
    d = cpu_rdata;
    rf = cpu_refused;
    chk(cpu_rvalid, 1'b1);
    @(posedge sys_clk);
  endtask
  task automatic jt(input fps_pkg::fps_jtag_op_t op, input logic [17:0] a, input logic [7:0] v);
    jtag_req <= '{1'b1, op, a, v};
    @(posedge sys_clk);
    jtag_req.valid <= 1'b0;
    #1;
    c = arr_cmd;
    for (bc = 0; bc < 60 && jtag_done !== 1'b1; bc++) begin
      @(posedge sys_clk);
      #1;
    end
    d = jtag_rdata;
    rf = jtag_refused;
    chk(jtag_done, 1'b1);
    @(posedge sys_clk);
  endtask
  ////////////////////////////////////////
  task automatic t_xram();
    wr(16'h1234, 8'h5a);
    chk({x, c.valid}, {1'b1, 16'h1234, 8'h5a, 1'b0});
    psc <= 8'h01;
    @(posedge sys_clk);
    wr(16'h1234, 8'h00);
    chk({x.valid, c.valid}, 2'h0);
    psc <= 8'h00;
    @(posedge sys_clk);
    wr(16'h0042, 8'h24);
    chk({x.valid, c.valid}, 2'h2);
  endtask
  task automatic t_byte();
    on(8'h01, 8'h00);
    wr(16'h1234, 8'h3c);
    chk_cmd(fps_pkg::ARR_PROG, 18'h0_1234);
    chk({c.nbytes, c.data[7:0]}, {3'h1, 8'h3c});
    wr(16'h1400, 8'h11);
    chk_cmd(fps_pkg::ARR_PROG, 18'h0_1400);
    bc1 = bc;
    fsc <= 8'h00;
    @(posedge sys_clk);
    wr(16'h1235, 8'h00);
    chk(c.valid, 1'b0);
    off();
    rd(16'h1234);
    chk({rf, d}, 9'h03c);
  endtask
  task automatic t_erase();
    lat <= 4'h6;
    on(8'h03, 8'h00);
    wr(16'h1234, 8'h00);
    chk_cmd(fps_pkg::ARR_ERASE_PAGE, 18'h0_1000);
    chk(bc >= 6, 1'b1);
    off();
    lat <= 4'h1;
    rd(16'h1234);
    chk({rf, d}, 9'h0ff);
    rd(16'h1400);
    chk({rf, d}, 9'h011);
  endtask
  task automatic t_block();
    w = 32'ha3a2_ffa0;
    on(8'h01, 8'h01);
    for (int i = 0; i < 3; i++) begin
      wr(16'h2000 + 16'(i), w[8*i +: 8]);
      chk(c.valid, 1'b0);
    end
    wr(16'h2003, w[31:24]);
    chk_cmd(fps_pkg::ARR_PROG, 18'h0_2000);
    chk({c.nbytes, c.data}, {3'h4, w});
    chk(bc, bc1);
    off();
    on(8'h05, 8'h01);
    wr(16'h0080, 8'h55);
    chk(c.valid, 1'b0);
    wr(16'h0081, 8'h66);
    chk_cmd(fps_pkg::ARR_PROG, 18'h2_0080);
    chk({c.nbytes, c.data[15:0]}, {3'h2, 16'h6655});
    off();
    on(8'h07, 8'h00);
    wr(16'h00f0, 8'h00);
    chk_cmd(fps_pkg::ARR_ERASE_PAGE, 18'h2_0080);
    off();
  endtask
  task automatic t_lock();
    bank <= 8'h30;
    on(8'h03, 8'h00);
    wr(16'hfbfe, 8'h00);
    chk(c.valid, 1'b0);
    off();
    on(8'h01, 8'h00);
    wr(16'hfbff, 8'h7e);
    chk_cmd(fps_pkg::ARR_PROG, 18'h1_fbff);
    off();
    bank <= 8'h00;
    cpu_pc <= 17'h0_0100;
    jt(fps_pkg::JT_READ, 18'h0_0100, 8'h00);
    chk({rf, d, dbg_blocked}, 10'h3ff);
    jt(fps_pkg::JT_READ, 18'h1_fbff, 8'h00);
    chk({rf, d}, 9'h07e);
    jt(fps_pkg::JT_READ, 18'h2_0000, 8'h00);
    chk(rf, 1'b0);
    jt(fps_pkg::JT_WRITE, 18'h1_fbfe, 8'h7f);
    jt(fps_pkg::JT_WRITE, 18'h1_c000, 8'h00);
    chk({rf, c.valid}, 2'h2);
    jt(fps_pkg::JT_WRITE, 18'h1_fbff, 8'h7c);
    chk({rf, c.valid}, 2'h1);
    jt(fps_pkg::JT_ERASE, 18'h1_f800, 8'h00);
    chk(rf, 1'b1);
    jt(fps_pkg::JT_ERASE, 18'h1_fbfe, 8'h00);
    chk({rf, c.valid, c.op}, {2'h1, fps_pkg::ARR_ERASE_ALL});
    jt(fps_pkg::JT_ERASE, 18'h1_f800, 8'h00);
    chk_cmd(fps_pkg::ARR_ERASE_PAGE, 18'h1_f800);
    jt(fps_pkg::JT_READ, 18'h0_0100, 8'h00);
    chk({rf, d, dbg_blocked}, 10'h1fe);
  endtask
  task automatic t_limit();
    acl_wdata <= 8'h02;
    acl_wr <= 1'b1;
    @(posedge sys_clk);
    acl_wdata <= 8'h05;
    @(posedge sys_clk);
    acl_wr <= 1'b0;
    cpu_pc <= 17'h0_0400;
    @(posedge sys_clk);
    chk(flash_access_limit, 8'h02);
    rd(16'h03ff);
    chk({rf, d}, 9'h1ff);
    on(8'h01, 8'h00);
    wr(16'h03ff, 8'h00);
    chk(c.valid, 1'b0);
    wr(16'h0400, 8'h77);
    chk_cmd(fps_pkg::ARR_PROG, 18'h0_0400);
    off();
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    final_report();
  end
  initial begin
    {rstn, acl_wr, psc, fsc, cch, bank, acl_wdata, cpu_pc} = '0;
    {cpu_req, jtag_req} = '0;
    lat = 4'h1;
    errors = 0;
    samples_checked = 0;
    repeat (12) @(posedge sys_clk);
    chk({flash_busy_flag, flash_access_limit}, 9'h000);
    rstn <= 1'b1;
    @(posedge sys_clk);
    t_xram();
    t_byte();
    t_erase();
    t_block();
    t_lock();
    t_limit();
    final_report();
  end
endmodule
`default_nettype wire
